// >>> slcd_bp_if.sv
`timescale 1ns/100ps
interface slcd_bp_if;
	logic                          osc_run;
	logic                          osc_clock;
	logic                          src_internal;
	logic                          bp_ext;
	logic [slcd_pkg::SEG_LINES-1:0] seg_ctrl;

	modport top (output osc_run, output src_internal, output bp_ext, output seg_ctrl, input osc_clock);
	modport osc (input osc_run, output osc_clock);
	modport drv (input osc_clock, input src_internal, input bp_ext, input seg_ctrl);
endinterface

// >>> slcd_chk.sv
`timescale 1ns/100ps
module slcd_chk #(
	parameter logic [19:0] BP_HALF_CYCLES = 20'h0000a
) (
	// Clock, reset and pins in.
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic [3:0]  dev_sel,
	input wire logic        scl_in,
	input wire logic        sda_in,
	input wire logic        backplane_clock,
	// Pins out.
	input wire logic        sda_out,
	input wire logic        sda_oe,
	input wire logic [13:0] segment_line,
	input wire logic        extra_segment_line,
	input wire logic        backplane_source_select,
	input wire logic        osc_power_down
);
	logic [19:0] cnt_r;
	logic        prev_r;
	logic        seen_r;
	wire  [6:0]  pat = segment_line[6:0] ^ {7{segment_line[7]}};

	// Counts cycles between toggles of the internal backplane.
	always_ff @(posedge sys_clk) begin
		prev_r <= extra_segment_line;
		if (!rst_n || !backplane_source_select) begin
			cnt_r <= 20'h00000;
			seen_r <= 1'b0;
		end else if (extra_segment_line != prev_r) begin
			cnt_r <= 20'h00000;
			seen_r <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 20'h00001;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_int_run;
		backplane_source_select [*3];
	endsequence
	sequence s_ext_run;
		!backplane_source_select [*4];
	endsequence

	a_osc_power_ctl: assert property (osc_power_down != backplane_source_select)
		else $error("oscillator power down disagrees with source select");
	a_fixed_segs: assert property (segment_line[13:7] == {7{segment_line[7]}})
		else $error("fixed segments differ");
	a_extra_int: assert property (s_int_run |-> extra_segment_line == segment_line[7])
		else $error("backplane output not the internal reference");
	a_extra_ext: assert property (s_ext_run |-> extra_segment_line == segment_line[7])
		else $error("extra segment not following backplane");
	a_ext_phase: assert property (s_ext_run |-> segment_line[7] == $past(backplane_clock, 3))
		else $error("segment not locked to backplane input");
	a_seg_bus_only: assert property ($past(rst_n, 2) && $changed(pat) |-> !scl_in)
		else $error("segment state changed outside a bus write");
	a_src_bus_only: assert property ($past(rst_n, 2) && $changed(backplane_source_select) |-> !scl_in)
		else $error("source select changed outside a bus write");
	a_half_period: assert property (backplane_source_select && seen_r && extra_segment_line != prev_r
		|-> cnt_r == BP_HALF_CYCLES - 20'h00001)
		else $error("backplane half period wrong");
	a_bp_alive: assert property (backplane_source_select |-> cnt_r < BP_HALF_CYCLES + 20'h00004)
		else $error("internal backplane stalled");
	a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data line moved while bus clock high");
	a_open_drain: assert property (sda_out == 1'b0)
		else $error("data output not open drain");
endmodule

bind slcd_top slcd_chk #(.BP_HALF_CYCLES(BP_HALF_CYCLES)) chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
	.dev_sel(dev_sel), .scl_in(scl_in), .sda_in(sda_in), .backplane_clock(backplane_clock),
	.sda_out(sda_out), .sda_oe(sda_oe), .segment_line(segment_line), .extra_segment_line(extra_segment_line),
	.backplane_source_select(backplane_source_select), .osc_power_down(osc_power_down));

// >>> slcd_host.sv
`timescale 1ns/100ps
module slcd_host (
	// Clock and device answer.
	input  wire logic sys_clk,
	input  wire logic sda_oe,
	// Bus wire levels and backplane.
	output logic      scl,
	output logic      sda,
	output logic      bp_ext
);
	logic       sda_r = 1'b1;
	logic       bp_run = 1'b0;
	logic [2:0] bp_cnt = 3'h0;
	initial scl = 1'b1;
	initial bp_ext = 1'b0;
	// Pulled-up data wire.
	assign sda = sda_r & (sda_oe !== 1'b1);
	always @(posedge sys_clk) begin
		#1;
		if (bp_run) begin
			bp_cnt = (bp_cnt == 3'h6) ? 3'h0 : bp_cnt + 3'h1;
			if (bp_cnt == 3'h0) bp_ext = ~bp_ext;
		end
	end
	task automatic half();
		repeat (6) @(posedge sys_clk);
		#1;
	endtask
	task automatic byte_io(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
		logic [8:0] v;
		logic [8:0] r;
		v = {tx, mack};
		for (int i = 8; i >= 0; i--) begin
			sda_r = v[i];
			half();
			scl = 1'b1;
			half();
			r[i] = sda;
			scl = 1'b0;
			half();
		end
		rx = r[8:1];
		ack = r[0];
	endtask
	// One addressed transfer, start to stop.
	task automatic xfer(input logic [6:0] adr, input logic rd, input logic [7:0] d,
		output logic [7:0] rx, output logic ack);
		logic [7:0] dummy;
		logic       a2;
		sda_r = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda_r = 1'b0;
		half();
		scl = 1'b0;
		half();
		byte_io({adr, rd}, 1'b1, dummy, ack);
		byte_io(rd ? 8'hff : d, 1'b1, rx, a2);
		sda_r = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda_r = 1'b1;
		half();
	endtask
endmodule

// >>> slcd_osc.sv
`timescale 1ns/100ps
module slcd_osc #(
	parameter logic [19:0] HALF_CYCLES = 20'(slcd_pkg::BP_HALF_CYCLES)
) (
	// Clock and reset.
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// Control and clock out.
	slcd_bp_if.osc    bp
);

	logic [slcd_pkg::BP_CNT_W-1:0] cnt_r;
	logic [slcd_pkg::BP_CNT_W-1:0] cnt_nxt;
	logic                          clk_r;
	logic                          clk_nxt;

	// The divider stops and parks low while powered down.
	always_comb begin
		cnt_nxt = cnt_r;
		clk_nxt = clk_r;
		if (!bp.osc_run) begin
			cnt_nxt = '0;
			clk_nxt = 1'b0;
		end else if (cnt_r == HALF_CYCLES - 20'h00001) begin
			cnt_nxt = '0;
			clk_nxt = ~clk_r;
		end else begin
			cnt_nxt = cnt_r + 20'h00001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cnt_r <= '0;
			clk_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			clk_r <= clk_nxt;
		end
	end

	assign bp.osc_clock = clk_r;

endmodule

// >>> slcd_pkg.sv
package slcd_pkg;

	// System clock and backplane timing.
	localparam int CLK_FREQ_HZ    = 50_000_000;
	localparam int BP_FREQ_HZ     = 48;
	localparam int BP_HALF_CYCLES = CLK_FREQ_HZ / (2 * BP_FREQ_HZ);
	localparam int BP_CNT_W       = 20;

	// Segment counts.
	localparam int SEG_PINS       = 14;
	localparam int SEG_LINES      = 15;
	localparam int BUS_SEG_LINES  = 7;

	// Control byte layout and reset value.
	localparam int CTRL_W         = 8;
	localparam int CTRL_SRC_BIT   = 7;
	localparam logic [7:0] CTRL_RESET = 8'h80;

	// Fixed-state source for segment lines 8 to 15.
	localparam logic [7:0] FIXED_SEG_STATE = 8'h00;

	// Slave address: fixed upper bits, four selectable low bits.
	localparam int DEV_SEL_W      = 4;
	localparam logic [2:0] ADDR_UPPER = 3'h0;
	localparam int ADDR_W         = 7;
	localparam logic [3:0] BIT_CNT_LAST = 4'h8;

	// Serial slave states.
	typedef enum logic [6:0] {
		SLCD_IDLE = 7'h01,
		SLCD_ADDR = 7'h02,
		SLCD_AACK = 7'h04,
		SLCD_WDAT = 7'h08,
		SLCD_WACK = 7'h10,
		SLCD_RDAT = 7'h20,
		SLCD_RACK = 7'h40
	} slcd_state_t;

endpackage

// >>> slcd_seg_drv.sv
`timescale 1ns/100ps
module slcd_seg_drv (
	// Clock and reset.
	input  wire logic                          sys_clk,
	input  wire logic                          rst_n,
	// Control from the top.
	slcd_bp_if.drv                             bp,
	// Panel outputs.
	output logic      [slcd_pkg::SEG_PINS-1:0] segment_line,
	output logic                               extra_segment_line
);

	logic                          ref_clk;
	logic [slcd_pkg::SEG_PINS-1:0] seg_nxt;
	logic                          pin20_nxt;

	always_comb begin
		ref_clk   = bp.src_internal ? bp.osc_clock : bp.bp_ext;
		seg_nxt   = bp.seg_ctrl[slcd_pkg::SEG_PINS-1:0] ^ {slcd_pkg::SEG_PINS{ref_clk}};
		pin20_nxt = bp.src_internal ? bp.osc_clock
		                            : (bp.seg_ctrl[slcd_pkg::SEG_LINES-1] ^ ref_clk);
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			segment_line       <= '0;
			extra_segment_line <= 1'b0;
		end else begin
			segment_line       <= seg_nxt;
			extra_segment_line <= pin20_nxt;
		end
	end

endmodule

// >>> slcd_tb.sv
`timescale 1ns/100ps
module tb;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  dev_sel = 4'h3;
	logic        scl;
	logic        sda;
	logic        sda_out;
	logic        sda_oe;
	logic        bp_ext;
	logic [13:0] seg;
	logic        extra;
	logic        src;
	logic        pd;
	logic [7:0]  rx;
	logic        ack;
	int          n_errors = 0;
	int          tests_run = 0;
	int          cycles = 0;
	always #10 sys_clk = ~sys_clk;
	slcd_host host_u (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda), .bp_ext(bp_ext));
	slcd_top #(.BP_HALF_CYCLES(20'h0000a)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .dev_sel(dev_sel),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .backplane_clock(bp_ext),
		.segment_line(seg), .extra_segment_line(extra), .backplane_source_select(src), .osc_power_down(pd));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	function automatic logic [6:0] pat();
		return seg[6:0] ^ {7{seg[7]}};
	endfunction
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic t_reset();
		chk(pd, 0);
		chk(src, 1);
		chk(pat(), 0);
		chk(sda_out, 0);
		chk(sda_oe, 0);
		$display("test reset done");
	endtask
	task automatic t_dark();
		logic e;
		int   n;
		host_u.xfer(7'h03, 1'b0, 8'h85, rx, ack);
		chk(ack, 0);
		tick(2);
		chk(pat(), 7'h05);
		chk(seg[13:7], {7{seg[7]}});
		e = extra;
		for (n = 0; n < 40 && extra === e; n++) tick(1);
		e = extra;
		for (n = 0; n < 40 && extra === e; n++) tick(1);
		chk(n, 10);
		chk(seg[7], extra);
		host_u.xfer(7'h03, 1'b1, 8'h00, rx, ack);
		chk(rx, 8'h85);
		$display("test dark done");
	endtask
	task automatic t_wrong();
		dev_sel = 4'h5;
		host_u.xfer(7'h03, 1'b0, 8'h7f, rx, ack);
		chk(ack, 1);
		chk(pat(), 7'h05);
		dev_sel = 4'h3;
		$display("test address done");
	endtask
	task automatic t_ext();
		logic e;
		int   n;
		host_u.xfer(7'h03, 1'b0, 8'h2a, rx, ack);
		tick(3);
		chk(pd, 1);
		chk(src, 0);
		host_u.bp_run = 1'b1;
		repeat (3) begin
			e = bp_ext;
			for (n = 0; n < 20 && bp_ext === e; n++) tick(1);
			tick(5);
			chk(seg[7], bp_ext);
			chk(extra, bp_ext);
			chk(pat(), 7'h2a);
		end
		host_u.bp_run = 1'b0;
		host_u.xfer(7'h03, 1'b0, 8'h80, rx, ack);
		tick(3);
		chk(pd, 0);
		$display("test external done");
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 10000) begin
			n_errors++;
			conclude();
		end
	end
	initial begin
		tick(2);
		rst_n = 1'b1;
		tick(4);
		t_reset();
		t_dark();
		t_wrong();
		t_ext();
		conclude();
	end
endmodule

// >>> slcd_top.sv
`timescale 1ns/100ps
module slcd_top #(
	parameter logic [19:0] BP_HALF_CYCLES = 20'(slcd_pkg::BP_HALF_CYCLES)
) (
	// Clock and reset.
	input  wire logic                          sys_clk,
	input  wire logic                          rst_n,
	// Device address select.
	input  wire logic [slcd_pkg::DEV_SEL_W-1:0] dev_sel,
	// Serial bus pins.
	input  wire logic                          scl_in,
	input  wire logic                          sda_in,
	output logic                               sda_out,
	output logic                               sda_oe,
	// Backplane input pin.
	input  wire logic                          backplane_clock,
	// Panel outputs.
	output logic      [slcd_pkg::SEG_PINS-1:0] segment_line,
	output logic                               extra_segment_line,
	// Status.
	output logic                               backplane_source_select,
	output logic                               osc_power_down
);

	slcd_bp_if bp ();

	// Input synchronisers.
	logic                           scl_meta_r;
	logic                           scl_meta_nxt;
	logic                           scl_sync_r;
	logic                           scl_sync_nxt;
	logic                           scl_prev_r;
	logic                           scl_prev_nxt;
	logic                           sda_meta_r;
	logic                           sda_meta_nxt;
	logic                           sda_sync_r;
	logic                           sda_sync_nxt;
	logic                           sda_prev_r;
	logic                           sda_prev_nxt;
	logic                           bp_meta_r;
	logic                           bp_meta_nxt;
	logic                           bp_sync_r;
	logic                           bp_sync_nxt;
	logic [slcd_pkg::DEV_SEL_W-1:0] dev_meta_r;
	logic [slcd_pkg::DEV_SEL_W-1:0] dev_meta_nxt;
	logic [slcd_pkg::DEV_SEL_W-1:0] dev_sel_r;
	logic [slcd_pkg::DEV_SEL_W-1:0] dev_sel_nxt;

	always_comb begin
		scl_meta_nxt = scl_in;
		scl_sync_nxt = scl_meta_r;
		scl_prev_nxt = scl_sync_r;
		sda_meta_nxt = sda_in;
		sda_sync_nxt = sda_meta_r;
		sda_prev_nxt = sda_sync_r;
		bp_meta_nxt  = backplane_clock;
		bp_sync_nxt  = bp_meta_r;
		dev_meta_nxt = dev_sel;
		dev_sel_nxt  = dev_meta_r;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			scl_meta_r <= 1'b1;
			scl_sync_r <= 1'b1;
			scl_prev_r <= 1'b1;
			sda_meta_r <= 1'b1;
			sda_sync_r <= 1'b1;
			sda_prev_r <= 1'b1;
			bp_meta_r  <= 1'b0;
			bp_sync_r  <= 1'b0;
			dev_meta_r <= '0;
			dev_sel_r  <= '0;
		end else begin
			scl_meta_r <= scl_meta_nxt;
			scl_sync_r <= scl_sync_nxt;
			scl_prev_r <= scl_prev_nxt;
			sda_meta_r <= sda_meta_nxt;
			sda_sync_r <= sda_sync_nxt;
			sda_prev_r <= sda_prev_nxt;
			bp_meta_r  <= bp_meta_nxt;
			bp_sync_r  <= bp_sync_nxt;
			dev_meta_r <= dev_meta_nxt;
			dev_sel_r  <= dev_sel_nxt;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	always_comb begin
		scl_rise  = scl_sync_r & ~scl_prev_r;
		scl_fall  = ~scl_sync_r & scl_prev_r;
		start_det = scl_sync_r & scl_prev_r & sda_prev_r & ~sda_sync_r;
		stop_det  = scl_sync_r & scl_prev_r & ~sda_prev_r & sda_sync_r;
	end

	// Compares a received address byte with this device's address.
	function automatic logic addr_match(input logic [7:0] rx, input logic [3:0] sel);
		addr_match = (rx[7:1] == {slcd_pkg::ADDR_UPPER, sel});
	endfunction

	// Shifts one received bit into the byte in hand.
	function automatic logic [7:0] shift_in(input logic [7:0] cur, input logic bit_in);
		shift_in = {cur[6:0], bit_in};
	endfunction

	// Advances the bit counter of the byte in flight.
	function automatic logic [3:0] count_up(input logic [3:0] cnt);
		count_up = cnt + 4'h1;
	endfunction

	// Serial slave state.
	slcd_pkg::slcd_state_t state_r;
	slcd_pkg::slcd_state_t state_nxt;
	logic [7:0]            shift_r;
	logic [7:0]            shift_nxt;
	logic [3:0]            bit_cnt_r;
	logic [3:0]            bit_cnt_nxt;
	logic                  rd_r;
	logic                  rd_nxt;
	logic                  sda_oe_r;
	logic                  sda_oe_nxt;
	logic [7:0]            ctrl_r;
	logic [7:0]            ctrl_nxt;

	always_comb begin
		state_nxt   = state_r;
		shift_nxt   = shift_r;
		bit_cnt_nxt = bit_cnt_r;
		rd_nxt      = rd_r;
		sda_oe_nxt  = sda_oe_r;
		ctrl_nxt    = ctrl_r;
		if (start_det) begin
			state_nxt   = slcd_pkg::SLCD_ADDR;
			bit_cnt_nxt = '0;
			sda_oe_nxt  = 1'b0;
		end else if (stop_det) begin
			state_nxt  = slcd_pkg::SLCD_IDLE;
			sda_oe_nxt = 1'b0;
		end else begin
			case (state_r)
				slcd_pkg::SLCD_IDLE: begin
					sda_oe_nxt = 1'b0;
				end
				slcd_pkg::SLCD_ADDR: begin
					if (scl_rise) begin
						shift_nxt   = shift_in(shift_r, sda_sync_r);
						bit_cnt_nxt = count_up(bit_cnt_r);
					end else if (scl_fall && bit_cnt_r == slcd_pkg::BIT_CNT_LAST) begin
						if (addr_match(shift_r, dev_sel_r)) begin
							state_nxt  = slcd_pkg::SLCD_AACK;
							rd_nxt     = shift_r[0];
							sda_oe_nxt = 1'b1;
						end else begin
							state_nxt = slcd_pkg::SLCD_IDLE;
						end
					end
				end
				slcd_pkg::SLCD_AACK: begin
					if (scl_fall) begin
						bit_cnt_nxt = '0;
						if (rd_r) begin
							state_nxt  = slcd_pkg::SLCD_RDAT;
							shift_nxt  = ctrl_r;
							sda_oe_nxt = ~ctrl_r[7];
						end else begin
							state_nxt  = slcd_pkg::SLCD_WDAT;
							sda_oe_nxt = 1'b0;
						end
					end
				end
				slcd_pkg::SLCD_WDAT: begin
					if (scl_rise) begin
						shift_nxt   = shift_in(shift_r, sda_sync_r);
						bit_cnt_nxt = count_up(bit_cnt_r);
					end else if (scl_fall && bit_cnt_r == slcd_pkg::BIT_CNT_LAST) begin
						ctrl_nxt   = shift_r;
						state_nxt  = slcd_pkg::SLCD_WACK;
						sda_oe_nxt = 1'b1;
					end
				end
				slcd_pkg::SLCD_WACK: begin
					if (scl_fall) begin
						state_nxt   = slcd_pkg::SLCD_WDAT;
						bit_cnt_nxt = '0;
						sda_oe_nxt  = 1'b0;
					end
				end
				slcd_pkg::SLCD_RDAT: begin
					if (scl_rise) begin
						bit_cnt_nxt = count_up(bit_cnt_r);
					end else if (scl_fall) begin
						if (bit_cnt_r == slcd_pkg::BIT_CNT_LAST) begin
							state_nxt  = slcd_pkg::SLCD_RACK;
							sda_oe_nxt = 1'b0;
						end else begin
							shift_nxt  = {shift_r[6:0], 1'b0};
							sda_oe_nxt = ~shift_r[6];
						end
					end
				end
				slcd_pkg::SLCD_RACK: begin
					if (scl_rise && sda_sync_r) begin
						state_nxt = slcd_pkg::SLCD_IDLE;
					end else if (scl_fall) begin
						state_nxt   = slcd_pkg::SLCD_RDAT;
						bit_cnt_nxt = '0;
						shift_nxt   = ctrl_r;
						sda_oe_nxt  = ~ctrl_r[7];
					end
				end
				default: begin
					state_nxt  = slcd_pkg::SLCD_IDLE;
					sda_oe_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_r   <= slcd_pkg::SLCD_IDLE;
			shift_r   <= '0;
			bit_cnt_r <= '0;
			rd_r      <= 1'b0;
			sda_oe_r  <= 1'b0;
			ctrl_r    <= slcd_pkg::CTRL_RESET;
		end else begin
			state_r   <= state_nxt;
			shift_r   <= shift_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			rd_r      <= rd_nxt;
			sda_oe_r  <= sda_oe_nxt;
			ctrl_r    <= ctrl_nxt;
		end
	end

	// Status flops and oscillator run control.
	logic run_r;
	logic run_nxt;
	logic src_r;
	logic src_nxt;
	logic pd_r;
	logic pd_nxt;
	logic sda_out_r;
	logic sda_out_nxt;

	// The data line is open drain, so only its enable ever moves.
	always_comb begin
		run_nxt     = ctrl_r[slcd_pkg::CTRL_SRC_BIT];
		src_nxt     = ctrl_r[slcd_pkg::CTRL_SRC_BIT];
		pd_nxt      = ~ctrl_r[slcd_pkg::CTRL_SRC_BIT];
		sda_out_nxt = 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			run_r     <= 1'b0;
			src_r     <= 1'b0;
			pd_r      <= 1'b1;
			sda_out_r <= 1'b0;
		end else begin
			run_r     <= run_nxt;
			src_r     <= src_nxt;
			pd_r      <= pd_nxt;
			sda_out_r <= sda_out_nxt;
		end
	end

	assign sda_out                 = sda_out_r;
	assign sda_oe                  = sda_oe_r;
	assign backplane_source_select = src_r;
	assign osc_power_down          = pd_r;

	// Segment lines 8 to 15 come from a constant source.
	assign bp.osc_run      = run_r;
	assign bp.src_internal = src_r;
	assign bp.bp_ext       = bp_sync_r;
	assign bp.seg_ctrl     = {slcd_pkg::FIXED_SEG_STATE, ctrl_r[slcd_pkg::BUS_SEG_LINES-1:0]};

	slcd_osc #(
		.HALF_CYCLES (BP_HALF_CYCLES)
	) u_osc (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.bp      (bp.osc)
	);

	slcd_seg_drv u_drv (
		.sys_clk            (sys_clk),
		.rst_n              (rst_n),
		.bp                 (bp.drv),
		.segment_line       (segment_line),
		.extra_segment_line (extra_segment_line)
	);

endmodule
